// file: bench/tb_uafm_core.sv
// Self-checking bench for the serial frame engine: frames out, frames in, flags.
// Assumes the remote model on the pins and timer overflows made here on clk_sys.
`timescale 1ns/1ns
module tb_uafm_core;
  import uafm_pkg::*;
  logic clk_sys = 1'h0;
  logic timer1Ovf = 1'h0;
  logic timer2Ovf = 1'h0;
  logic rst_b, tx_timer2_select, rxTimer2Select, rateWrite, rateFast, bufWrite;
  logic tx_ninth_bit, addr_filter_enable, txDoneClear, rxDoneClear, rxLine;
  logic txLine, txBusy, rx_ninth_bit, tx_done_flag, rx_done_flag, serialIrq;
  logic [1:0] modeSel;
  logic [7:0] bufWriteData, serial_data_buffer;
  int err_total, num_checks, cyc, tc;

  uafm_core DUT (.clk_sys, .rst_b, .modeSel, .timer1Ovf, .timer2Ovf, .tx_timer2_select,
    .rxTimer2Select, .rateWrite, .rateFast, .bufWrite, .bufWriteData, .tx_ninth_bit,
    .addr_filter_enable, .txDoneClear, .rxDoneClear, .rxLine, .txLine, .txBusy,
    .serial_data_buffer, .rx_ninth_bit, .tx_done_flag, .rx_done_flag, .serialIrq);
  uafm_remote_dev remote (.clk_sys, .lineIn(txLine), .lineOut(rxLine));

  always #4 clk_sys = ~clk_sys;

  // Timer 1 ticks every 2nd cycle, timer 2 every 3rd, so a wrong source shows
  always @(negedge clk_sys) begin
    tc <= tc + 1;
    timer1Ovf <= (tc % 2 == 0);
    timer2Ovf <= (tc % 3 == 0);
  end

  // Cycle ceiling: thirteen frames need far less than this
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      conclude();
    end
  end

  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic writeBuf(input logic [7:0] d, input logic nb);
    @(negedge clk_sys);
    bufWriteData = d;
    tx_ninth_bit = nb;
    bufWrite = 1'h1;
    @(negedge clk_sys);
    bufWrite = 1'h0;
    @(negedge clk_sys);
    check("tx busy", {10'h0, txBusy}, 11'h1);
  endtask

  // Clear both flags; the interrupt lags one cycle, so allow two edges
  task automatic clearFlags();
    @(negedge clk_sys);
    txDoneClear = 1'h1;
    rxDoneClear = 1'h1;
    @(negedge clk_sys);
    txDoneClear = 1'h0;
    rxDoneClear = 1'h0;
    @(negedge clk_sys);
    check("flags clear", {8'h0, tx_done_flag, rx_done_flag, serialIrq}, 11'h0);
  endtask

  task automatic txTest(input logic [7:0] d, input logic nb, input int n, input int bc);
    logic [10:0] f;
    fork
      remote.getFrame(f, n, bc);
      writeBuf(d, nb);
    join
    check("tx frame", f, {1'h1, (n == 10) ? 1'h1 : nb, d, 1'h0});
    check("tx done", {8'h0, txBusy, tx_done_flag, serialIrq}, 11'h3);
    clearFlags();
  endtask

  task automatic rxTest(input logic [10:0] f, input int n, input int bc, input logic [8:0] exp,
                        input logic fl);
    remote.sendFrame(f, n, bc);
    check("rx data", {2'h0, rx_ninth_bit, serial_data_buffer}, {2'h0, exp});
    check("rx done", {10'h0, rx_done_flag}, {10'h0, fl});
    repeat (bc) @(negedge clk_sys);
  endtask

  // Main sequence: mode 1 both ways, refusals, then modes 2 and 3
  initial begin
    rst_b = 1'h0;
    modeSel = MODE_UART8;
    {tx_timer2_select, rxTimer2Select, rateWrite, rateFast, bufWrite} = 5'h0;
    {tx_ninth_bit, addr_filter_enable, txDoneClear, rxDoneClear} = 4'h0;
    bufWriteData = 8'h0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check("reset pins", {5'h0, txLine, txBusy, tx_done_flag, rx_done_flag, serialIrq, rx_ninth_bit},
          11'h20);
    check("reset buffer", {3'h0, serial_data_buffer}, {3'h0, BUF_RESET});
    rst_b = 1'h1;
    repeat (20) @(negedge clk_sys);
    txTest(8'hA5, 1'h0, 10, 32);
    tx_timer2_select = 1'h1;
    txTest(8'h01, 1'h0, 10, 48);
    rxTimer2Select = 1'h1;
    rxTest({2'h3, 8'h3C, 1'h0}, 10, 48, 9'h13C, 1'h1);
    rxTest({2'h3, 8'hC3, 1'h0}, 10, 48, 9'h13C, 1'h1);
    clearFlags();
    remote.pulseLow(8);
    repeat (100) @(negedge clk_sys);
    check("glitch", {10'h0, rx_done_flag}, 11'h0);
    rxTest({2'h3, 8'h5A, 1'h0}, 10, 48, 9'h15A, 1'h1);
    clearFlags();
    addr_filter_enable = 1'h1;
    rxTest({2'h2, 8'h77, 1'h0}, 10, 48, 9'h15A, 1'h0);
    rxTest({2'h3, 8'h88, 1'h0}, 10, 48, 9'h188, 1'h1);
    clearFlags();
    modeSel = MODE_FIXED9;
    txTest(8'h96, 1'h1, 11, 32);
    @(negedge clk_sys);
    rateFast = 1'h1;
    rateWrite = 1'h1;
    @(negedge clk_sys);
    rateWrite = 1'h0;
    txTest(8'h69, 1'h0, 11, 16);
    modeSel = MODE_VAR9;
    rxTimer2Select = 1'h0;
    rxTest({2'h1, 8'hE1, 1'h0}, 11, 32, 9'h1E1, 1'h1);
    clearFlags();
    rxTest({2'h2, 8'h1E, 1'h0}, 11, 32, 9'h1E1, 1'h0);
    addr_filter_enable = 1'h0;
    rxTest({2'h2, 8'h2D, 1'h0}, 11, 32, 9'h02D, 1'h1);
    clearFlags();
    txTest(8'hF0, 1'h1, 11, 48);
    conclude();
  end
endmodule

// file: bench/uafm_remote_dev.sv
// Remote serial device: drives the device's receive pin, captures its transmit pin.
// Assumes bit periods given in clk_sys cycles; the line rests high between frames.
`timescale 1ns/1ns
module uafm_remote_dev (
  input wire logic clk_sys,
  input wire logic lineIn,
  output logic lineOut
);
  initial lineOut = 1'h1;

  // Frame out LSB first: start low, data, stop high; idle high afterwards
  task automatic sendFrame(input logic [10:0] bits, input int n, input int bc);
    for (int i = 0; i < n; i++) begin
      lineOut = bits[i];
      repeat (bc) @(negedge clk_sys);
    end
    lineOut = 1'h1;
  endtask

  // Short low glitch, too short to survive the start-bit vote
  task automatic pulseLow(input int c);
    lineOut = 1'h0;
    repeat (c) @(negedge clk_sys);
    lineOut = 1'h1;
  endtask

  // Capture at mid-bit; a missing start leaves all ones so the caller sees a mismatch
  task automatic getFrame(output logic [10:0] bits, input int n, input int bc);
    int w;
    bits = '1;
    w = 0;
    while (lineIn !== 1'h0 && w < 4000) begin
      @(negedge clk_sys);
      w++;
    end
    repeat (bc / 2) @(negedge clk_sys);
    for (int i = 0; i < n; i++) begin
      bits[i] = lineIn;
      repeat (bc) @(negedge clk_sys);
    end
  endtask
endmodule

// file: verilog/uafm_bit_voter.sv
// Two-of-three bit detector for the receive path.
// Assumes sampleEn pulses three times per bit, lastSample marking the third.
`timescale 1ns/1ns
module uafm_bit_voter
  import uafm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sampleEn,
  input wire logic lastSample,
  input wire logic lineLevel,
  output logic voteValue,
  output logic voteValid
);
  logic [1:0] earlier;

  // Keep the two earlier samples of the bit
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      earlier <= 2'h0;
    end else if (sampleEn) begin
      earlier <= {earlier[0], lineLevel};
    end
  end

  // Majority rejects a single noisy sample
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      voteValue <= LINE_IDLE;
      voteValid <= 1'b0;
    end else begin
      voteValid <= sampleEn && lastSample;
      if (sampleEn && lastSample) begin
        voteValue <= (earlier[1] & earlier[0]) | (earlier[1] & lineLevel) | (earlier[0] & lineLevel);
      end
    end
  end

  property p_majority;
    @(posedge clk_sys) disable iff (!rst_b)
    sampleEn && lastSample && !lineLevel && !earlier[0] |=> !voteValue && voteValid;
  endproperty
  a_majority: assert property (p_majority) else $error("two low samples did not give a low vote");
endmodule

// file: verilog/uafm_core.sv
// Asynchronous transmit and receive engine for the 10-bit and 11-bit frame modes.
// Assumes timer overflows and core strobes are one-cycle pulses on clk_sys;
// rxLine comes from a pin and is synchronised here.
`timescale 1ns/1ns
module uafm_core
  import uafm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [1:0] modeSel,
  input wire logic timer1Ovf,
  input wire logic timer2Ovf,
  input wire logic tx_timer2_select,
  input wire logic rxTimer2Select,
  input wire logic rateWrite,
  input wire logic rateFast,
  input wire logic bufWrite,
  input wire logic [7:0] bufWriteData,
  input wire logic tx_ninth_bit,
  input wire logic addr_filter_enable,
  input wire logic txDoneClear,
  input wire logic rxDoneClear,
  input wire logic rxLine,
  output logic txLine,
  output logic txBusy,
  output logic [7:0] serial_data_buffer,
  output logic rx_ninth_bit,
  output logic tx_done_flag,
  output logic rx_done_flag,
  output logic serialIrq
);
  uafm_tx_e txState;
  uafm_rx_e rxState;
  logic mode2Fast, slowToggle, fixedTick, txTick, rxTick, txRoll, txReq, txShifted, txFinish;
  logic rxMeta, rxSync, rxPrev, rxFall, sampleEn, voteValue, voteValid, rxFinal, rxLoad;
  logic [3:0] txCount, rxCount;
  logic [8:0] txShift, rxShift;

  // Mode 2 divisor control; reset leaves the slower rate selected
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mode2Fast <= MODE2_FAST_RESET;
    end else if (rateWrite) begin
      mode2Fast <= rateFast;
    end
  end
  // Halving toggle gives the 16x tick of the slow fixed rate
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      slowToggle <= 1'b0;
    end else begin
      slowToggle <= !slowToggle;
    end
  end
  // 16x ticks per direction; the shift mode gets none and stays idle
  always_comb begin
    fixedTick = mode2Fast | slowToggle;
    case (modeSel)
      MODE_FIXED9: begin
        txTick = fixedTick;
        rxTick = fixedTick;
      end
      MODE_UART8, MODE_VAR9: begin
        txTick = tx_timer2_select ? timer2Ovf : timer1Ovf;
        rxTick = rxTimer2Select ? timer2Ovf : timer1Ovf;
      end
      default: begin
        txTick = 1'b0;
        rxTick = 1'b0;
      end
    endcase
  end
  // Transmit divide-by-16; bit times follow its rollovers, not the write
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      txCount <= COUNT_RESET;
    end else if (txTick) begin
      txCount <= txCount + 4'h1;
    end
  end
  assign txRoll = txTick && (txCount == BIT_LAST);
  assign txFinish = txRoll && (txState == TX_DATA) && txShifted && (txShift[8:2] == 7'h00) && txShift[1];
  // Pending request; a write once the frame has started is ignored so the frame is not torn
  // The start consumes it first, else a write on that rollover would resend
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      txReq <= 1'b0;
    end else if (txRoll && (txState == TX_IDLE) && txReq) begin
      txReq <= 1'b0;
    end else if (bufWrite && (txState == TX_IDLE)) begin
      txReq <= 1'b1;
    end
  end
  // Transmit sequencer: start bit, data phase, shifting, final shift
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      txState <= TX_IDLE;
      txShift <= TX_SHIFT_RESET;
      txShifted <= 1'b0;
      txLine <= LINE_IDLE;
    end else begin
      if (bufWrite && (txState == TX_IDLE)) begin
        // Marker one in mode 1, ninth data bit otherwise
        txShift <= {(modeSel == MODE_UART8) ? 1'b1 : tx_ninth_bit, bufWriteData};
      end
      if (txRoll) begin
        case (txState)
          TX_IDLE: begin
            if (txReq) begin
              txState <= TX_START;
              txLine <= 1'b0;
              txShifted <= 1'b0;
            end
          end
          TX_START: begin
            txState <= TX_DATA;
            txLine <= txShift[0];
          end
          TX_DATA: begin
            if (txFinish) begin
              // Last shift leaves the stop level on the line
              txState <= TX_IDLE;
              txLine <= LINE_IDLE;
            end else begin
              // First shift inserts the stop one in the 11-bit modes
              txShift <= {!txShifted && (modeSel != MODE_UART8), txShift[8:1]};
              txLine <= txShift[1];
              txShifted <= 1'b1;
            end
          end
          default: begin
            txState <= TX_IDLE;
            txLine <= LINE_IDLE;
          end
        endcase
      end
    end
  end
  // Busy lags the sequencer by one cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      txBusy <= 1'b0;
    end else begin
      txBusy <= txReq || (txState != TX_IDLE);
    end
  end
  // Transmit done flag; completion wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tx_done_flag <= 1'b0;
    end else if (txFinish) begin
      tx_done_flag <= 1'b1;
    end else if (txDoneClear) begin
      tx_done_flag <= 1'b0;
    end
  end
  // Two-flop synchroniser, then the previous 16x sample for edge hunting
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rxMeta <= LINE_IDLE;
      rxSync <= LINE_IDLE;
      rxPrev <= LINE_IDLE;
    end else begin
      rxMeta <= rxLine;
      rxSync <= rxMeta;
      if (rxTick) begin
        rxPrev <= rxSync;
      end
    end
  end
  assign rxFall = rxTick && (rxState == RX_HUNT) && rxPrev && !rxSync;
  // Receive divide-by-16, realigned to each start edge
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rxCount <= COUNT_RESET;
    end else if (rxFall) begin
      rxCount <= COUNT_RESET;
    end else if (rxTick) begin
      rxCount <= rxCount + 4'h1;
    end
  end
  assign sampleEn = rxTick && (rxState != RX_HUNT) && (rxCount >= SAMPLE_FIRST) && (rxCount <= SAMPLE_LAST);
  uafm_bit_voter voter (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .sampleEn(sampleEn),
    .lastSample(rxCount == SAMPLE_LAST),
    .lineLevel(rxSync),
    .voteValue(voteValue),
    .voteValid(voteValid)
  );
  // Final shift is the vote that finds the start bit at the far end
  assign rxFinal = (rxState == RX_BITS) && voteValid && !rxShift[0];
  assign rxLoad = rxFinal && !rx_done_flag && (!addr_filter_enable || voteValue);
  // Receive sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rxState <= RX_HUNT;
      rxShift <= RX_SHIFT_INIT;
    end else begin
      case (rxState)
        RX_HUNT: begin
          if (rxFall) begin
            rxState <= RX_BITS;
            rxShift <= RX_SHIFT_INIT;
          end
        end
        RX_BITS: begin
          if (voteValid) begin
            if ((rxShift == RX_SHIFT_INIT) && voteValue) begin
              rxState <= RX_HUNT;
            end else if (rxFinal) begin
              // Mode 1 hunts at once; the 11-bit modes skip the stop bit
              rxState <= (modeSel == MODE_UART8) ? RX_HUNT : RX_STOP;
            end else begin
              rxShift <= {voteValue, rxShift[8:1]};
            end
          end
        end
        RX_STOP: begin
          if (voteValid) begin
            rxState <= RX_HUNT;
          end
        end
        default: begin
          rxState <= RX_HUNT;
        end
      endcase
    end
  end
  // Buffer and ninth bit change only on an accepted frame
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      serial_data_buffer <= BUF_RESET;
      rx_ninth_bit <= 1'b0;
    end else if (rxLoad) begin
      serial_data_buffer <= rxShift[8:1];
      rx_ninth_bit <= voteValue;
    end
  end
  // Receive done flag; a load wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rx_done_flag <= 1'b0;
    end else if (rxLoad) begin
      rx_done_flag <= 1'b1;
    end else if (rxDoneClear) begin
      rx_done_flag <= 1'b0;
    end
  end
  // Interrupt request follows the flags one cycle later
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      serialIrq <= 1'b0;
    end else begin
      serialIrq <= tx_done_flag || rx_done_flag;
    end
  end

  property p_txStartLow;
    @(posedge clk_sys) disable iff (!rst_b)
    txRoll && (txState == TX_IDLE) && txReq |=> !txLine && (txState == TX_START);
  endproperty
  a_txStartLow: assert property (p_txStartLow) else $error("start bit not driven low");
  property p_writeNoStart;
    @(posedge clk_sys) disable iff (!rst_b)
    bufWrite && (txState == TX_IDLE) && !txReq |=> (txState == TX_IDLE);
  endproperty
  a_writeNoStart: assert property (p_writeNoStart) else $error("sending began at the write");
  property p_txDone;
    @(posedge clk_sys) disable iff (!rst_b)
    txFinish |=> tx_done_flag && txLine && (txState == TX_IDLE);
  endproperty
  a_txDone: assert property (p_txDone) else $error("done flag or idle line missing after last shift");
  property p_rxEdge;
    @(posedge clk_sys) disable iff (!rst_b)
    rxFall |=> (rxShift == RX_SHIFT_INIT) && (rxCount == COUNT_RESET) && (rxState == RX_BITS);
  endproperty
  a_rxEdge: assert property (p_rxEdge) else $error("edge did not realign receiver");
  property p_falseStart;
    @(posedge clk_sys) disable iff (!rst_b)
    (rxState == RX_BITS) && voteValid && voteValue && (rxShift == RX_SHIFT_INIT) |=> (rxState == RX_HUNT);
  endproperty
  a_falseStart: assert property (p_falseStart) else $error("false start not rejected");
  property p_rxLoad;
    @(posedge clk_sys) disable iff (!rst_b)
    rxLoad |=> rx_done_flag && (serial_data_buffer == $past(rxShift[8:1])) && (rx_ninth_bit == $past(voteValue));
  endproperty
  a_rxLoad: assert property (p_rxLoad) else $error("accepted frame not stored");
  property p_rxDrop;
    @(posedge clk_sys) disable iff (!rst_b)
    rxFinal && rx_done_flag |=> $stable(serial_data_buffer) && $stable(rx_ninth_bit);
  endproperty
  a_rxDrop: assert property (p_rxDrop) else $error("blocked frame changed the buffer");
  property p_stopWait;
    @(posedge clk_sys) disable iff (!rst_b)
    rxFinal && (modeSel != MODE_UART8) |=> (rxState == RX_STOP);
  endproperty
  a_stopWait: assert property (p_stopWait) else $error("stop bit time not skipped");
  property p_irq;
    @(posedge clk_sys) disable iff (!rst_b)
    (tx_done_flag || rx_done_flag) |=> serialIrq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request missing while a flag is set");
  property p_rateReset;
    @(posedge clk_sys) !rst_b |=> !mode2Fast;
  endproperty
  a_rateReset: assert property (p_rateReset) else $error("reset did not pick slow rate");
  c_txDone: cover property (@(posedge clk_sys) disable iff (!rst_b) txFinish);
  c_rxLoad: cover property (@(posedge clk_sys) disable iff (!rst_b) rxLoad);
  c_falseStart: cover property (@(posedge clk_sys) disable iff (!rst_b)
    (rxState == RX_BITS) && voteValid && voteValue && (rxShift == RX_SHIFT_INIT));
  c_rxDrop: cover property (@(posedge clk_sys) disable iff (!rst_b) rxFinal && !rxLoad);
endmodule

// file: verilog/uafm_pkg.sv
// Shared constants and state types for the asynchronous serial frame engine.
// Assumes one system clock; every other rate arrives as a one-cycle tick.
package uafm_pkg;
  // Frame mode select codes
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_UART8 = 2'h1;
  localparam logic [1:0] MODE_FIXED9 = 2'h2;
  localparam logic [1:0] MODE_VAR9 = 2'h3;
  // Divide-by-16 counter states
  localparam logic [3:0] BIT_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_FIRST = 4'h7;
  localparam logic [3:0] SAMPLE_LAST = 4'h9;
  localparam logic [3:0] COUNT_RESET = 4'h0;
  // Shift register and output reset values
  localparam logic [8:0] RX_SHIFT_INIT = 9'h1FF;
  localparam logic [8:0] TX_SHIFT_RESET = 9'h000;
  localparam logic [7:0] BUF_RESET = 8'h00;
  localparam logic MODE2_FAST_RESET = 1'b0;
  localparam logic LINE_IDLE = 1'b1;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA} uafm_tx_e;
  typedef enum logic [1:0] {RX_HUNT, RX_BITS, RX_STOP} uafm_rx_e;
endpackage
